// ---- dv/iev_cpu_model.sv ----
`timescale 1ns/1ps
module iev_cpu_model
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        nrst,
    // vector handshake
    input wire logic        vector_valid,
    input wire logic [15:0] vector_code,
    input wire logic [31:0] vector_addr,
    input wire logic        vector_next_pc,
    output logic            cpu_ack,
    // bench control and capture
    input wire logic [3:0]  ack_delay,
    input wire logic        hold,
    output logic            got,
    output logic [15:0]     m_code,
    output logic [31:0]     m_addr,
    output logic            m_next
);
    logic [3:0] wait_cnt;

    // ack is raised only while a vector stands, so the vector is captured at the ack edge
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cpu_ack  <= 1'b0;
            got      <= 1'b0;
            wait_cnt <= 4'h0;
            m_code   <= 16'h0;
            m_addr   <= 32'h0;
            m_next   <= 1'b0;
        end
        else
        begin
            got <= cpu_ack;
            if (cpu_ack)
            begin
                cpu_ack  <= 1'b0;
                wait_cnt <= 4'h0;
                m_code   <= vector_code;
                m_addr   <= vector_addr;
                m_next   <= vector_next_pc;
            end
            else if (vector_valid && !hold)
            begin
                if (wait_cnt == ack_delay)
                    cpu_ack <= 1'b1;
                else
                    wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// ---- dv/iev_top_asserts.sv ----
`timescale 1ns/1ps
`include "iev_defs.svh"
module iev_top_asserts
(
    // clock and reset
    input wire logic                     core_clk,
    input wire logic                     nrst,
    // requests and configuration
    input wire logic                     trap_req,
    input wire logic [4:0]               trap_num,
    input wire logic                     watchdog_overflow_request,
    input wire logic                     internal_reset_req,
    input wire logic [`IEV_NUM_MASK-1:0] irq_mask,
    input wire logic                     int_enable,
    // core handshake and status
    input wire logic                     vector_valid,
    input wire logic [15:0]              vector_code,
    input wire logic [31:0]              vector_addr,
    input wire logic                     vector_next_pc,
    input wire logic                     cpu_ack,
    input wire logic [`IEV_NUM_MASK-1:0] pending,
    input wire logic                     nmi_busy
);
    logic [`IEV_NUM_MASK-1:0] mask_q;
    logic                     en_q;
    wire logic                mask_vec = vector_code >= `IEV_CODE_MASK0;
    wire logic [6:0]          vec_idx = vector_code[10:4] - 7'h08;

    // mask seen by the selection on the edge that loaded the vector
    always_ff @(posedge core_clk)
    begin
        mask_q <= irq_mask;
        en_q   <= int_enable;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    vector_hold_a: assert property (vector_valid && !cpu_ack && !internal_reset_req |=>
        vector_valid && $stable(vector_code) && $stable(vector_addr)) else $error("vector moved");
    addr_code_a: assert property (vector_valid && vector_code[15:5] != 11'h002 |->
        vector_addr == {16'h0000, vector_code}) else $error("handler address off");
    trap_addr_a: assert property (vector_valid && vector_code[15:5] == 11'h002 |->
        vector_addr == {16'h0000, vector_code[15:4], 4'h0}) else $error("trap address off");
    trap_vec_a: assert property (trap_req && !vector_valid && pending == '0 && !internal_reset_req
        |-> ##2 vector_valid && vector_code == {11'h002, $past(trap_num, 2)}) else $error("trap code");
    mask_gate_a: assert property ($rose(vector_valid) && mask_vec |-> en_q && !mask_q[vec_idx])
        else $error("masked request forwarded");
    nmi_block_a: assert property ($rose(vector_valid) && nmi_busy |-> !mask_vec)
        else $error("maskable during non-maskable service");
    reset_vec_a: assert property (internal_reset_req |=> vector_valid && vector_code == 16'h0000
        && vector_addr == 32'h0 && !vector_next_pc && pending == '0) else $error("reset vector");
    wdt_vec_a: assert property (watchdog_overflow_request && !vector_valid && !nmi_busy && !trap_req
        && pending == '0 |-> ##2 vector_valid && vector_code == `IEV_CODE_WDT) else $error("wdt code");

    cover property ($rose(vector_valid) && mask_vec);
    cover property (vector_valid && cpu_ack && vector_code == `IEV_CODE_NMI);
    cover property (internal_reset_req);
endmodule
bind iev_top iev_top_asserts chk_u (.*);

// ---- dv/interrupt_exception_vectoring_tb_top.sv ----
`timescale 1ns/1ps
module interrupt_exception_vectoring_tb_top;
    logic         core_clk, nrst, nmi_pin, watchdog_overflow_request, internal_reset_req;
    logic         trap_req, illegal_opcode_trap, debug_trap_instruction, int_enable;
    logic         vector_valid, vector_next_pc, cpu_ack, irq_return, nmi_return, nmi_busy;
    logic         hold, got, m_next;
    logic [1:0]   nmi_edge_sel;
    logic [3:0]   ack_delay;
    logic [4:0]   trap_num;
    logic [7:0]   in_service;
    logic [8:0]   ext_pin;
    logic [15:0]  vector_code, m_code;
    logic [17:0]  ext_edge_sel;
    logic [31:0]  vector_addr, m_addr;
    logic [59:0]  periph_req;
    logic [68:0]  irq_mask, pending;
    logic [206:0] irq_prio;
    int           n_errors, total_checks;

    iev_top dut_u (.*);
    iev_cpu_model cpu_u (.*);

    initial
    begin
        core_clk = 0;
        forever #50 core_clk = ~core_clk;
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task expect_vec(input logic [15:0] c, input logic [31:0] a);
        int i;
        i = 0;
        @(negedge core_clk);
        while (got !== 1'b1 && i < 200)
        begin
            @(negedge core_clk);
            i++;
        end
        chk({31'h0, got}, 32'h1);
        chk({16'h0, m_code}, {16'h0, c});
        chk(m_addr, a);
    endtask

    task expect_idx(input int idx);
        expect_vec(16'(128 + 16 * idx), 32'(128 + 16 * idx));
    endtask

    task expect_none(input int n);
        logic v;
        v = 0;
        repeat (n)
        begin
            @(negedge core_clk);
            v = v | vector_valid;
        end
        chk({31'h0, v}, 32'h0);
    endtask

    task preq(input logic [59:0] m);
        @(posedge core_clk);
        periph_req <= m;
        @(posedge core_clk);
        periph_req <= '0;
    endtask

    task rt(input logic n);
        @(posedge core_clk);
        if (n)
            nmi_return <= 1;
        else
            irq_return <= 1;
        @(posedge core_clk);
        nmi_return <= 0;
        irq_return <= 0;
    endtask

    task t_reset;
        @(posedge core_clk);
        hold <= 0;
        expect_vec(16'h0000, 32'h0);
        chk({31'h0, m_next}, 32'h0);
        @(posedge core_clk);
        internal_reset_req <= 1;
        @(posedge core_clk);
        internal_reset_req <= 0;
        expect_vec(16'h0000, 32'h0);
    endtask

    task t_traps;
        for (int n = 0; n < 34; n++)
        begin
            @(posedge core_clk);
            ack_delay <= 4'(n);
            trap_req <= n < 32;
            trap_num <= 5'(n);
            illegal_opcode_trap <= n == 32;
            debug_trap_instruction <= n == 33;
            @(posedge core_clk);
            {trap_req, illegal_opcode_trap, debug_trap_instruction} <= 3'h0;
            if (n < 32)
                expect_vec(16'(64 + n), n < 16 ? 32'h40 : 32'h50);
            else
                expect_vec(16'h0060, 32'h60);
        end
        ack_delay <= 4'h0;
    endtask

    task t_periph;
        for (int j = 0; j < 60; j++)
        begin
            preq(60'h1 << j);
            expect_idx(j == 0 ? 0 : j + 8);
            rt(0);
        end
    endtask

    task t_mask;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge core_clk);
            irq_mask[0] <= k == 0;
            int_enable <= k == 0;
            preq(60'h1);
            expect_none(10);
            chk({31'h0, pending[0]}, 32'h1);
            @(posedge core_clk);
            irq_mask[0] <= 0;
            int_enable <= 1;
            expect_idx(0);
            rt(0);
        end
    endtask

    task t_prio;
        @(posedge core_clk);
        irq_prio[35:27] <= {3'h0, 3'h2, 3'h5};
        preq(60'h6);
        expect_idx(10);
        expect_none(10);
        preq(60'h8);
        expect_idx(11);
        chk({24'h0, in_service}, 32'h5);
        rt(0);
        expect_none(10);
        rt(0);
        expect_idx(9);
        rt(0);
        preq(60'h30);
        expect_idx(12);
        rt(0);
        expect_idx(13);
        rt(0);
    endtask

    task t_ext;
        int p;
        for (int k = 0; k < 11; k++)
        begin
            // last two passes reuse pin 0: falling edge only, then both edges
            p = k > 8 ? 0 : k;
            @(posedge core_clk);
            ext_edge_sel[1:0] <= k == 9 ? 2'b01 : (k == 10 ? 2'b11 : 2'b10);
            ext_pin[p] <= 1;
            if (k == 9)
                expect_none(20);
            else
                expect_idx(k == 8 ? 68 : p + 1);
            rt(0);
            @(posedge core_clk);
            ext_pin[p] <= 0;
            if (k > 8)
                expect_idx(1);
            else
                expect_none(20);
            rt(0);
        end
    endtask

    task t_nmi;
        @(posedge core_clk);
        irq_mask <= '1;
        watchdog_overflow_request <= 1;
        @(posedge core_clk);
        watchdog_overflow_request <= 0;
        expect_vec(16'h0020, 32'h20);
        chk({31'h0, nmi_busy}, 32'h1);
        @(posedge core_clk);
        nmi_pin <= 1;
        irq_mask <= '0;
        preq(60'h1);
        expect_none(20);
        rt(1);
        expect_vec(16'h0010, 32'h10);
        chk({31'h0, m_next}, 32'h1);
        expect_none(10);
        rt(1);
        expect_idx(0);
        rt(0);
    endtask

    task give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        {nrst, nmi_pin, watchdog_overflow_request, internal_reset_req, trap_req} = '0;
        {illegal_opcode_trap, debug_trap_instruction, irq_return, nmi_return} = '0;
        {ext_pin, periph_req, irq_mask, trap_num, ack_delay} = '0;
        {n_errors, total_checks} = '0;
        irq_prio = {69{3'h3}};
        ext_edge_sel = {9{2'b10}};
        nmi_edge_sel = 2'b10;
        int_enable = 1;
        hold = 1;
        repeat (5) @(posedge core_clk);
        nrst <= 1;
        t_reset();
        t_traps();
        t_periph();
        t_mask();
        t_prio();
        t_ext();
        t_nmi();
        give_verdict();
    end

    // the whole run needs about 1500 cycles; the limit at 20000 cycles leaves a wide margin
    initial
    begin
        #2000000;
        n_errors++;
        give_verdict();
    end
endmodule

// ---- hdl/iev_defs.svh ----
// Function
// [RULE1] handle 71 interrupt requests: two non-maskable plus sixty-nine maskable
// [RULE2] two non-maskable sources ignore masks and priority levels
// [RULE3] maskable set: nine external pin requests and sixty internal peripheral requests
// [RULE4] each maskable request has a programmable priority of eight levels
// [RULE5] nested servicing: higher priority request may interrupt a running handler
// [RULE6] each maskable request has its own mask; masked requests are not forwarded
// [RULE7] external pins pass noise filter and software-selected edge detector
// [RULE8] trap instruction raises thirty-two software exceptions chosen by operand
// [RULE9] trap codes 004n/005n; handlers at 0x40 and 0x50
// [RULE10] illegal opcode and debug trap share code and handler 0x60
// [RULE11] any reset presents code zero, address zero, no return address
// [RULE12] non-maskable pin edge gives code 0x10, saves following instruction address
// [RULE13] eight pin requests at default priorities one to eight, codes 0x90 up by 16
// [RULE14] first timer overflow and four matches at priorities nine to thirteen
// [RULE15] four more timers, overflow and two matches each, priorities fourteen to twenty-five
// [RULE16] handler address equals code zero-extended, except shared trap group bases
// [RULE17] equal programmed level: lowest default priority number goes first
`ifndef IEV_DEFS_SVH
`define IEV_DEFS_SVH
`define IEV_NUM_MASK      69
`define IEV_NUM_EXT       9
`define IEV_NUM_INT       60
`define IEV_NUM_LEVELS    8
`define IEV_CODE_RESET    16'h0000
`define IEV_CODE_NMI      16'h0010
`define IEV_CODE_WDT      16'h0020
`define IEV_CODE_TRAP0    16'h0040
`define IEV_CODE_TRAP1    16'h0050
`define IEV_CODE_EXC      16'h0060
`define IEV_CODE_MASK0    16'h0080
`define IEV_EXT_LAST_IDX  68
`define IEV_CLK_NS        100
`define IEV_FILT_NS       300
`define IEV_FILT_CYC      ((`IEV_FILT_NS + `IEV_CLK_NS - 1) / `IEV_CLK_NS)
`define IEV_EDGE_RISE     1
`define IEV_EDGE_FALL     0
`endif

// ---- hdl/iev_pin_filter.sv ----
`timescale 1ns/1ps
`include "iev_defs.svh"
module iev_pin_filter
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pin side
    iev_pin_if.filt  pin
);
    localparam int CW = $clog2(`IEV_FILT_CYC + 1);
    localparam logic [CW-1:0] FILT_LAST = CW'(`IEV_FILT_CYC - 1);

    logic          sync1;
    logic          sync2;
    logic          level;
    logic [CW-1:0] stable_cnt;
    logic          pulse;

    wire differ  = sync2 != level;
    wire settled = differ && (stable_cnt == FILT_LAST);
    wire rise    = settled && sync2;
    wire fall    = settled && !sync2;
    wire hit     = (rise && pin.edge_sel[`IEV_EDGE_RISE])
                || (fall && pin.edge_sel[`IEV_EDGE_FALL]); // RULE7

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end
        else
        begin
            sync1 <= pin.pin_raw;
            sync2 <= sync1;
        end
    end

    // a change must hold for the whole window; shorter glitches restart the count
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            level      <= 1'b0;
            stable_cnt <= '0;
            pulse      <= 1'b0;
        end
        else
        begin
            stable_cnt <= (differ && !settled) ? stable_cnt + CW'(1) : '0; // RULE7
            if (settled)
                level <= sync2;
            pulse <= hit;
        end
    end

    assign pin.edge_pulse = pulse;
endmodule

// ---- hdl/iev_pin_if.sv ----
`timescale 1ns/1ps
interface iev_pin_if;
    logic       pin_raw;
    logic [1:0] edge_sel;
    logic       edge_pulse;
    modport filt (input pin_raw, input edge_sel, output edge_pulse);
    modport ctrl (output pin_raw, output edge_sel, input edge_pulse);
endinterface

// ---- hdl/iev_pkg.sv ----
package iev_pkg;
    typedef enum logic [1:0] {
        IEV_IDLE    = 2'b01,
        IEV_PRESENT = 2'b10
    } iev_state_t;
    typedef enum logic [2:0] {
        IEV_K_RESET = 3'h0,
        IEV_K_TRAP  = 3'h1,
        IEV_K_EXC   = 3'h2,
        IEV_K_NMI   = 3'h3,
        IEV_K_WDT   = 3'h4,
        IEV_K_MASK  = 3'h5
    } iev_kind_t;
endpackage

// ---- hdl/iev_top.sv ----
`timescale 1ns/1ps
`include "iev_defs.svh"
module iev_top
(
    // clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            nrst,
    // external pins, asynchronous
    input  wire logic [`IEV_NUM_EXT-1:0]         ext_pin,
    input  wire logic [2*`IEV_NUM_EXT-1:0]       ext_edge_sel,
    input  wire logic                            nmi_pin,
    input  wire logic [1:0]                      nmi_edge_sel,
    // internal request pulses, core clock
    input  wire logic [`IEV_NUM_INT-1:0]         periph_req,
    input  wire logic                            watchdog_overflow_request,
    input  wire logic                            internal_reset_req,
    // exceptions from the core
    input  wire logic                            trap_req,
    input  wire logic [4:0]                      trap_num,
    input  wire logic                            illegal_opcode_trap,
    input  wire logic                            debug_trap_instruction,
    // configuration
    input  wire logic [`IEV_NUM_MASK-1:0]        irq_mask,
    input  wire logic [3*`IEV_NUM_MASK-1:0]      irq_prio,
    input  wire logic                            int_enable,
    // core handshake
    output logic                                 vector_valid,
    output logic [15:0]                          vector_code,
    output logic [31:0]                          vector_addr,
    output logic                                 vector_next_pc,
    input  wire logic                            cpu_ack,
    input  wire logic                            irq_return,
    input  wire logic                            nmi_return,
    // status
    output logic [`IEV_NUM_MASK-1:0]             pending,
    output logic [`IEV_NUM_LEVELS-1:0]           in_service,
    output logic                                 nmi_busy
);
    localparam int NM = `IEV_NUM_MASK;

    iev_pkg::iev_state_t state;
    iev_pkg::iev_kind_t  sel_kind;
    logic [6:0]          sel_idx;
    logic [2:0]          sel_lvl;
    logic                trap_pend;
    logic [4:0]          trap_num_q;
    logic                exc_pend;
    logic                nmi_pend;
    logic                wdt_pend;
    logic [`IEV_NUM_EXT-1:0] ext_evt;
    logic                nmi_evt;
    logic [NM-1:0]       raw_evt;
    logic                best_found;
    logic [6:0]          best_idx;
    logic [2:0]          best_lvl;
    logic [3:0]          cur_level;

    // one filter per pin, the non-maskable pin last
    genvar g;
    generate
        for (g = 0; g <= `IEV_NUM_EXT; g++)
        begin : g_pin
            iev_pin_if pif ();
            iev_pin_filter u_filt
            (
                .core_clk (core_clk),
                .nrst     (nrst),
                .pin      (pif.filt)
            );
            if (g < `IEV_NUM_EXT)
            begin : g_ext
                assign pif.pin_raw  = ext_pin[g];
                assign pif.edge_sel = ext_edge_sel[2*g +: 2];
                assign ext_evt[g]   = pif.edge_pulse;
            end
            else
            begin : g_nmi
                assign pif.pin_raw  = nmi_pin;
                assign pif.edge_sel = nmi_edge_sel;
                assign nmi_evt      = pif.edge_pulse;
            end
        end
    endgenerate

    // default priority order: low voltage, pins 0-7, timers, other internals, ninth pin
    assign raw_evt[0]                    = periph_req[0];
    assign raw_evt[8:1]                  = ext_evt[7:0]; // RULE13
    assign raw_evt[67:9]                 = periph_req[59:1]; // RULE14 RULE15
    assign raw_evt[`IEV_EXT_LAST_IDX]    = ext_evt[8]; // RULE3

    // lowest set in-service bit is the level now running; 8 means none
    always_comb
    begin
        cur_level = 4'h8;
        for (int l = `IEV_NUM_LEVELS - 1; l >= 0; l--)
            if (in_service[l])
                cur_level = 4'(l); // RULE5
    end

    // strict compare while walking upward keeps the lowest index on a tie
    always_comb
    begin
        best_found = 1'b0;
        best_idx   = 7'h00;
        best_lvl   = 3'h7;
        for (int i = 0; i < NM; i++)
            if (pending[i] && !irq_mask[i]                              // RULE6
                && (!best_found || irq_prio[3*i +: 3] < best_lvl))      // RULE4 RULE17
            begin
                best_found = 1'b1;
                best_idx   = 7'(i);
                best_lvl   = irq_prio[3*i +: 3];
            end
    end

    wire mask_ok   = best_found && int_enable && !nmi_busy
                  && ({1'b0, best_lvl} < cur_level); // RULE5
    wire wdt_ok    = wdt_pend && !nmi_busy;
    wire nmi_ok    = nmi_pend && !nmi_busy;
    wire cand      = trap_pend || exc_pend || nmi_ok || wdt_ok || mask_ok;
    wire take      = (state == iev_pkg::IEV_IDLE) && cand;
    wire acked     = (state == iev_pkg::IEV_PRESENT) && cpu_ack;
    wire ack_mask  = acked && (sel_kind == iev_pkg::IEV_K_MASK);
    wire ack_nmi   = acked && (sel_kind == iev_pkg::IEV_K_NMI);
    wire ack_wdt   = acked && (sel_kind == iev_pkg::IEV_K_WDT);
    wire ack_trap  = acked && (sel_kind == iev_pkg::IEV_K_TRAP);
    wire ack_exc   = acked && (sel_kind == iev_pkg::IEV_K_EXC);

    wire [15:0] mask_code = `IEV_CODE_MASK0 + {5'h00, best_idx, 4'h0}; // RULE13 RULE14 RULE15
    wire [15:0] trap_code = (trap_num_q[4] ? `IEV_CODE_TRAP1 : `IEV_CODE_TRAP0)
                          | {12'h000, trap_num_q[3:0]}; // RULE8 RULE9
    wire [15:0] trap_base = trap_num_q[4] ? `IEV_CODE_TRAP1 : `IEV_CODE_TRAP0; // RULE16

    wire [NM-1:0] clr_vec = ack_mask ? (NM'(1) << sel_idx) : '0;
    wire [7:0]    lvl_set = ack_mask ? (8'h01 << sel_lvl) : 8'h00;
    wire [7:0]    lvl_clr = (irq_return && cur_level != 4'h8)
                          ? (8'h01 << cur_level[2:0]) : 8'h00;

    // new events win over the clear that an acknowledge makes
    wire [NM-1:0] next_pending = (pending & ~clr_vec) | raw_evt;
    wire [7:0]    next_in_service = (in_service & ~lvl_clr) | lvl_set;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pending    <= '0;
            in_service <= 8'h00;
            nmi_busy   <= 1'b0;
            trap_pend  <= 1'b0;
            trap_num_q <= 5'h00;
            exc_pend   <= 1'b0;
            nmi_pend   <= 1'b0;
            wdt_pend   <= 1'b0;
        end
        else if (internal_reset_req)
        begin
            pending    <= '0;
            in_service <= 8'h00;
            nmi_busy   <= 1'b0;
            trap_pend  <= 1'b0;
            exc_pend   <= 1'b0;
            nmi_pend   <= 1'b0;
            wdt_pend   <= 1'b0;
        end
        else
        begin
            pending    <= next_pending; // RULE1
            in_service <= next_in_service; // RULE5
            nmi_busy   <= (ack_nmi || ack_wdt) || (nmi_busy && !nmi_return); // RULE2
            trap_pend  <= trap_req || (trap_pend && !ack_trap);
            if (trap_req)
                trap_num_q <= trap_num; // RULE8
            exc_pend   <= illegal_opcode_trap || debug_trap_instruction
                       || (exc_pend && !ack_exc); // RULE10
            nmi_pend   <= nmi_evt || (nmi_pend && !ack_nmi); // RULE12
            wdt_pend   <= watchdog_overflow_request || (wdt_pend && !ack_wdt); // RULE2
        end
    end

    // the vector holds still until the core takes it or an internal reset replaces it; later arrivals wait their turn
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state          <= iev_pkg::IEV_PRESENT;
            sel_kind       <= iev_pkg::IEV_K_RESET;
            sel_idx        <= 7'h00;
            sel_lvl        <= 3'h0;
            vector_code    <= `IEV_CODE_RESET; // RULE11
            vector_addr    <= 32'h0000_0000; // RULE11
            vector_next_pc <= 1'b0;
        end
        else if (internal_reset_req)
        begin
            state          <= iev_pkg::IEV_PRESENT;
            sel_kind       <= iev_pkg::IEV_K_RESET;
            vector_code    <= `IEV_CODE_RESET; // RULE11
            vector_addr    <= 32'h0000_0000; // RULE11
            vector_next_pc <= 1'b0;
        end
        else
        begin
            unique case (state)
                iev_pkg::IEV_IDLE:
                begin
                    if (take)
                    begin
                        state          <= iev_pkg::IEV_PRESENT;
                        vector_next_pc <= 1'b1; // RULE12
                        if (trap_pend)
                        begin
                            sel_kind    <= iev_pkg::IEV_K_TRAP;
                            vector_code <= trap_code; // RULE9
                            vector_addr <= {16'h0000, trap_base}; // RULE9 RULE16
                        end
                        else if (exc_pend)
                        begin
                            sel_kind    <= iev_pkg::IEV_K_EXC;
                            vector_code <= `IEV_CODE_EXC; // RULE10
                            vector_addr <= {16'h0000, `IEV_CODE_EXC}; // RULE10
                        end
                        else if (nmi_ok)
                        begin
                            sel_kind    <= iev_pkg::IEV_K_NMI;
                            vector_code <= `IEV_CODE_NMI; // RULE12
                            vector_addr <= {16'h0000, `IEV_CODE_NMI}; // RULE12
                        end
                        else if (wdt_ok)
                        begin
                            sel_kind    <= iev_pkg::IEV_K_WDT;
                            vector_code <= `IEV_CODE_WDT; // RULE2
                            vector_addr <= {16'h0000, `IEV_CODE_WDT}; // RULE16
                        end
                        else
                        begin
                            sel_kind    <= iev_pkg::IEV_K_MASK;
                            sel_idx     <= best_idx;
                            sel_lvl     <= best_lvl;
                            vector_code <= mask_code;
                            vector_addr <= {16'h0000, mask_code}; // RULE16
                        end
                    end
                end
                iev_pkg::IEV_PRESENT:
                begin
                    if (cpu_ack)
                        state <= iev_pkg::IEV_IDLE;
                end
                default:
                    state <= iev_pkg::IEV_IDLE;
            endcase
        end
    end

    assign vector_valid = (state == iev_pkg::IEV_PRESENT);
endmodule
